// ### inc/psim_consts.vh
`ifndef PSIM_CONSTS_VH
`define PSIM_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define PSIM_OFF_VOLT_FLAGS   8'h00
`define PSIM_OFF_GLOBAL_MASK  8'h02
`define PSIM_OFF_VOLT_MASK    8'h03
`define PSIM_OFF_LIVE         8'h04
`define PSIM_OFF_PART_ID      8'h05
// ****************************************
// reset values
// ****************************************
`define PSIM_RST_GLOBAL_MASK  8'h01
`define PSIM_RST_VOLT_MASK    6'h00
`define PSIM_RST_LIVE         6'h00
// ****************************************
// field positions
// ****************************************
`define PSIM_VM_LOW_LSB       3
`define PSIM_VM_GOOD_LSB      0
`define PSIM_LIVE_CAL_BIT     5
`define PSIM_LIVE_TEMP_BIT    4
`define PSIM_LIVE_SUPPLY_BIT  3
`define PSIM_LIVE_C_BIT       2
`define PSIM_LIVE_B_BIT       1
`define PSIM_LIVE_A_BIT       0
`define PSIM_ID_REV_LSB       5
`define PSIM_ID_PART_LSB      0
// ****************************************
// identity (arbitrary values)
// ****************************************
`define PSIM_REVISION_CODE    3'h2
`define PSIM_PART_CODE        5'h0a
`endif

// ### verilog/psim_status_irq.v
`timescale 1ns/1ps
`include "psim_consts.vh"

module psim_status_irq (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] global_flags,
  input  wire       calibration_busy_in,
  input  wire       thermal_high_in,
  input  wire       supply_low_in,
  input  wire       out_c_regulating_in,
  input  wire       out_b_regulating_in,
  input  wire       out_a_regulating_in,
  input  wire       out_c_valid,
  input  wire       out_b_valid,
  input  wire       out_a_valid,
  input  wire [2:0] conversion_period_setting,
  output reg  [5:0] voltage_flags,
  output reg        irq_out
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] global_event_mask;
  reg  [5:0] voltage_event_mask;
  reg  [5:0] live_condition_view;
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  reg  [2:0] reg_prev;
  reg  [7:0] next_rdata;
  wire [2:0] reg_now;
  wire [2:0] reg_valid;
  wire [5:0] next_flags;
  wire       wr_vflags;
  wire       next_irq;

  // live inputs come from analog/other domains, so two stages first
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end
    else
    begin
      sync_a <= {calibration_busy_in, thermal_high_in, supply_low_in,
                 out_c_regulating_in, out_b_regulating_in, out_a_regulating_in};
      sync_b <= sync_a;
    end
  end

  assign reg_now   = sync_b[2:0];
  assign reg_valid = {out_c_valid, out_b_valid, out_a_valid};

  // ****************************************
  // mask registers
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      global_event_mask  <= `PSIM_RST_GLOBAL_MASK;
      voltage_event_mask <= `PSIM_RST_VOLT_MASK;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `PSIM_OFF_GLOBAL_MASK)
        global_event_mask <= reg_wdata;
      if (reg_addr == `PSIM_OFF_VOLT_MASK)
        voltage_event_mask <= reg_wdata[5:0];
    end
  end

  // ****************************************
  // live view
  // ****************************************
  // temp/supply only refresh while periodic conversions run
  always @(posedge clk_sys)
  begin
    if (rst)
      live_condition_view <= `PSIM_RST_LIVE;
    else
    begin
      live_condition_view[`PSIM_LIVE_CAL_BIT] <= sync_b[5];
      if (conversion_period_setting != 3'h0)
      begin
        live_condition_view[`PSIM_LIVE_TEMP_BIT]   <= sync_b[4];
        live_condition_view[`PSIM_LIVE_SUPPLY_BIT] <= sync_b[3];
      end
      // regulation bits pass live; only meaningful while output valid
      live_condition_view[`PSIM_LIVE_C_BIT] <= reg_now[2] & reg_valid[2];
      live_condition_view[`PSIM_LIVE_B_BIT] <= reg_now[1] & reg_valid[1];
      live_condition_view[`PSIM_LIVE_A_BIT] <= reg_now[0] & reg_valid[0];
    end
  end

  // ****************************************
  // latched voltage flags
  // ****************************************
  assign wr_vflags = reg_wr & (reg_addr == `PSIM_OFF_VOLT_FLAGS);

  // set beats write-one clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_out
      wire fell;
      wire rose;
      assign fell = reg_valid[i] & reg_prev[i] & ~reg_now[i];
      assign rose = reg_valid[i] & ~reg_prev[i] & reg_now[i];
      assign next_flags[`PSIM_VM_LOW_LSB + i] = fell |
        (voltage_flags[`PSIM_VM_LOW_LSB + i] &
         ~(wr_vflags & reg_wdata[`PSIM_VM_LOW_LSB + i]));
      assign next_flags[`PSIM_VM_GOOD_LSB + i] = rose |
        (voltage_flags[`PSIM_VM_GOOD_LSB + i] &
         ~(wr_vflags & reg_wdata[`PSIM_VM_GOOD_LSB + i]));
    end
  endgenerate

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_prev      <= 3'h0;
      voltage_flags <= 6'h00;
    end
    else
    begin
      reg_prev      <= reg_now;
      voltage_flags <= next_flags;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  assign next_irq = (|(global_flags & global_event_mask)) |
                    (|(voltage_flags & voltage_event_mask));

  always @(posedge clk_sys)
  begin
    if (rst)
      irq_out <= 1'b0;
    else
      irq_out <= next_irq;
  end

  // ****************************************
  // read path
  // ****************************************
  always @*
  begin
    case (reg_addr)
      `PSIM_OFF_VOLT_FLAGS:   next_rdata = {2'b00, voltage_flags};
      `PSIM_OFF_GLOBAL_MASK:  next_rdata = global_event_mask;
      `PSIM_OFF_VOLT_MASK:    next_rdata = {2'b00, voltage_event_mask};
      `PSIM_OFF_LIVE:         next_rdata = {2'b00, live_condition_view};
      `PSIM_OFF_PART_ID:      next_rdata = {`PSIM_REVISION_CODE, `PSIM_PART_CODE};
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule // psim_status_irq

// ### bench/psim_host_model.sv
`timescale 1ns/1ps
module psim_host_model (
  input wire logic clk_sys,
  input wire logic irq_out,
  output int       irq_edges
);
  logic irq_q = 1'b0;
  initial irq_edges = 0;
  // host services each new request once
  always @(posedge clk_sys)
  begin
    irq_q <= irq_out;
    if (irq_out && !irq_q)
      irq_edges <= irq_edges + 1;
  end
endmodule // psim_host_model

// ### bench/psim_status_irq_asserts.sv
`timescale 1ns/1ps
`include "psim_consts.vh"
// ****************************************
// checker
// ****************************************
module psim_status_irq_chk (
  input wire logic       clk_sys, rst, reg_wr, reg_rd, irq_out,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, global_flags,
  input wire logic [5:0] voltage_flags
);
  logic [7:0] gm;
  logic [5:0] vm;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // masks are shadowed since no port shows them
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      gm <= 8'h01;
      vm <= 6'h00;
    end
    else if (reg_wr && reg_addr == 8'h02)
      gm <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h03)
      vm <= reg_wdata[5:0];
  end
  a_irq_mask: assert property (!$past(rst) |->
    irq_out == |{$past(global_flags & gm), $past(voltage_flags & vm)}) else $error("irq");
  a_gm_rd: assert property (reg_rd && reg_addr == 8'h02 |=>
    reg_rdata == $past(gm)) else $error("gm");
  a_vm_rd: assert property (reg_rd && reg_addr == 8'h03 |=>
    reg_rdata == {2'b00, $past(vm)}) else $error("vm");
  a_live_rsv: assert property (reg_rd && reg_addr == 8'h04 |=>
    reg_rdata[7:6] == 2'b00) else $error("live");
  a_id_rd: assert property (reg_rd && reg_addr == 8'h05 |=>
    reg_rdata == {`PSIM_REVISION_CODE, `PSIM_PART_CODE}) else $error("id");
  a_vf_clear: assert property (!$past(rst) |-> ($past(voltage_flags) &
    ~voltage_flags & ~($past(reg_wr && reg_addr == 8'h00) ? $past(reg_wdata[5:0]) : 6'h00))
    == 6'h00) else $error("vf");
  a_rst_irq: assert property ($fell(rst) && global_flags[0] |=> irq_out)
    else $error("rst irq");
  a_wr_irq: assert property (reg_wr && reg_addr == 8'h02 ##1
    |($past(reg_wdata) & global_flags) |=> irq_out) else $error("wr irq");
endmodule // psim_status_irq_chk
bind psim_status_irq psim_status_irq_chk u_psim_status_irq_chk (.*);

// ### bench/psim_status_irq_test.sv
`timescale 1ns/1ps
`include "psim_consts.vh"
module psim_status_irq_test;
  logic       clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, cal = 0, hot = 0, low = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, global_flags = 8'h01;
  logic [2:0] regu = 0, vld = 0, per = 0;
  wire  [7:0] reg_rdata;
  wire  [5:0] voltage_flags;
  wire        irq_out;
  int         n_errors = 0, num_checks = 0, cyc = 0, irq_edges, i;
  always #4 clk_sys = ~clk_sys;
  psim_status_irq u_psim_status_irq (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_flags(global_flags), .calibration_busy_in(cal), .thermal_high_in(hot),
    .supply_low_in(low), .out_c_regulating_in(regu[2]), .out_b_regulating_in(regu[1]),
    .out_a_regulating_in(regu[0]), .out_c_valid(vld[2]), .out_b_valid(vld[1]),
    .out_a_valid(vld[0]), .conversion_period_setting(per), .voltage_flags(voltage_flags),
    .irq_out(irq_out));
  psim_host_model u_psim_host_model (.clk_sys(clk_sys), .irq_out(irq_out),
    .irq_edges(irq_edges));
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(logic [7:0] a, d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(logic [7:0] a, e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // lag covers the two-stage input sync
  task w(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    w(2);
    chk("irq", 1, irq_out);
    rd(8'h02, 8'h01);
    rd(8'h03, 8'h00);
    rd(8'h05, {`PSIM_REVISION_CODE, `PSIM_PART_CODE});
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h02, 8'(1 << i));
      global_flags <= 8'(~(1 << i));
      w(2);
      chk("irq", 0, irq_out);
      @(posedge clk_sys);
      global_flags <= 8'(1 << i);
      w(2);
      chk("irq", 1, irq_out);
    end
    wr(8'h02, 8'h01);
    {global_flags, per, vld, regu, cal, hot, low} <= {8'h00, 3'h1, 3'h7, 3'h7, 3'h7};
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h3f);
    w(6);
    rd(8'h04, 8'h3f);
    wr(8'h00, 8'h3f);
    for (i = 0; i < 3; i++)
    begin
      regu[i] <= 0;
      w(6);
      chk("vflags", 8'(8 << i), {2'b00, voltage_flags});
      chk("irq", 1, irq_out);
      rd(8'h00, 8'(8 << i));
      wr(8'h00, 8'h3f);
      regu[i] <= 1;
      w(6);
      chk("vflags", 8'(1 << i), {2'b00, voltage_flags});
      wr(8'h00, 8'h3f);
      w(2);
      chk("irq", 0, irq_out);
    end
    wr(8'h03, 8'h00);
    regu[0] <= 0;
    w(6);
    chk("irq", 0, irq_out);
    rd(8'h00, 8'h08);
    @(posedge clk_sys);
    vld <= 0;
    w(6);
    rd(8'h04, 8'h38);
    {per, hot, low} <= 5'h00;
    w(6);
    rd(8'h04, 8'h38);
    per <= 3'h1;
    w(6);
    rd(8'h04, 8'h20);
    chk("edges", 1, irq_edges > 8);
    $display("mask and live tests done");
    summarize();
  end
endmodule // psim_status_irq_test
